// >>> paec_phy_model.sv
// Purpose: PHY-side source of autoneg events and line levels.
// Assumes: Called from the bench by task; one clock.
// Notes: Event pulses last one clock.
`timescale 1ns/100ps
module paec_phy_model (
  input  wire logic clk_i,
  output logic      pd_fault_o,
  output logic      pd_active_o,
  output logic      page_rx_o,
  output logic      partner_np_o,
  output logic      partner_an_o,
  output logic      sig_det_o,
  output logic      link_up_o
);
  initial begin
    {pd_fault_o, page_rx_o} = 2'b00;
    {pd_active_o, partner_np_o, partner_an_o, sig_det_o, link_up_o} = 5'h00;
  end
  task automatic pulse(input logic fault);
    @(posedge clk_i);
    pd_fault_o <= fault;
    page_rx_o  <= ~fault;
    @(posedge clk_i);
    {pd_fault_o, page_rx_o} <= 2'b00;
  endtask : pulse
  // Order: fault active, partner np, partner an, signal, link
  task automatic levels(input logic [4:0] v);
    @(posedge clk_i);
    {pd_active_o, partner_np_o, partner_an_o, sig_det_o, link_up_o} <= v;
  endtask : levels
endmodule : paec_phy_model

// >>> paec_pkg.sv
// Purpose: Constants for the autoneg expansion and PHY config registers.
// Assumes: Classic Wishbone, 32-bit data, 100 MHz clock.
// Notes: Function
package paec_pkg;
  localparam int          ADR_W          = 8;
  localparam int          REG_W          = 16;
  localparam int          IRQ_W          = 3;
  // Register indices; byte address is four times the index
  localparam logic [5:0]  XSTAT_IDX      = 6'h06;
  localparam logic [5:0]  CFG_IDX        = 6'h10;
  localparam logic [5:0]  IRQ_STAT_IDX   = 6'h20;
  localparam logic [5:0]  IRQ_MASK_IDX   = 6'h21;
  localparam logic [7:0]  XSTAT_ADDR     = {XSTAT_IDX, 2'b00};
  localparam logic [7:0]  CFG_ADDR       = {CFG_IDX, 2'b00};
  localparam logic [7:0]  IRQ_STAT_ADDR  = {IRQ_STAT_IDX, 2'b00};
  localparam logic [7:0]  IRQ_MASK_ADDR  = {IRQ_MASK_IDX, 2'b00};
  // Expansion register fields
  localparam int          AN_FAULT       = 4;
  localparam int          AN_LP_NP       = 3;
  localparam int          AN_NP          = 2;
  localparam int          AN_PAGE_RX     = 1;
  localparam int          AN_LP_AN       = 0;
  // Config register fields
  localparam int          CF_CODING      = 15;
  localparam int          CF_SCRAMBLER   = 14;
  localparam int          CF_ALIGN       = 13;
  localparam int          CF_SIG_DET     = 12;
  localparam int          CF_TX100       = 10;
  localparam int          CF_FLINK       = 7;
  localparam int          CF_ARPD        = 4;
  localparam int          CF_SM_RESET    = 3;
  localparam int          CF_PREAMBLE    = 2;
  localparam int          CF_SLEEP       = 1;
  localparam int          CF_LOOPOUT     = 0;
  localparam logic [15:0] CFG_RESET      = 16'h0410;
  localparam logic [15:0] CFG_WMASK      = 16'hf097;
  // Interrupt status fields
  localparam int          IRQ_FAULT      = 0;
  localparam int          IRQ_PAGE       = 1;
  localparam int          IRQ_SMDONE     = 2;
  localparam logic [2:0]  IRQ_MASK_RESET = 3'h0;
  // State machine reset pulse length
  localparam int          CLK_PERIOD_NS  = 10;
  localparam int          SM_RESET_NS    = 100;
  localparam int          SM_RESET_CYCLES = (SM_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_HOLD = 2'b01,
    SEQ_DONE = 2'b11
  } paec_seq_state_t;
endpackage : paec_pkg

// >>> paec_regs.sv
// Purpose: Autoneg expansion status and PHY config registers, Wishbone slave.
// Assumes: PHY-side inputs are synchronous to clk_i.
// Notes: Unmapped addresses ack with zero data; writes there are dropped.
`timescale 1ns/100ps
module paec_regs (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [paec_pkg::ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [31:0]                 wb_dat_i,
  output logic      [31:0]                 wb_dat_o,
  output logic                             wb_ack_o,
  input  wire logic                        pd_fault_i,
  input  wire logic                        pd_fault_active_i,
  input  wire logic                        page_rx_i,
  input  wire logic                        partner_np_i,
  input  wire logic                        partner_an_i,
  input  wire logic                        signal_detect_i,
  input  wire logic                        link_up_i,
  output logic                             coding_bypass_o,
  output logic                             scrambler_bypass_o,
  output logic                             alignment_bypass_o,
  output logic                             signal_detect_o,
  output logic                             link_status_o,
  output logic                             force_link_100_o,
  output logic                             arpd_enable_o,
  output logic                             sm_reset_o,
  output logic                             preamble_suppress_o,
  output logic                             sleep_o,
  output logic                             remote_loop_out_o,
  output logic                             irq_o
);
  import paec_pkg::*;

  logic                 ack_q;
  logic [31:0]          dat_q;
  logic                 take;
  logic                 wr;
  logic                 rd;
  logic [REG_W-1:0]     cfg_q;
  logic [REG_W-1:0]     cfg_d;
  logic                 fault_q;
  logic                 page_q;
  logic                 lp_np_q;
  logic                 lp_an_q;
  logic [IRQ_W-1:0]     irq_stat_q;
  logic [IRQ_W-1:0]     irq_mask_q;
  logic                 sigdet_q;
  logic                 link_q;
  logic                 sm_start;
  logic                 sm_busy;
  logic                 sm_done;
  logic                 wake;

  function automatic logic [REG_W-1:0] merge16(input logic [REG_W-1:0] old,
                                               input logic [31:0]      dat,
                                               input logic [3:0]       sel);
    logic [REG_W-1:0] res;
    res = old;
    if (sel[0]) begin
      res[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      res[15:8] = dat[15:8];
    end
    return res;
  endfunction : merge16

  function automatic logic hit(input logic [ADR_W-1:0] adr,
                               input logic [ADR_W-1:0] reg_addr);
    return adr == reg_addr;
  endfunction : hit

  // Bus handshake: one wait state, ack for one cycle
  assign take     = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr       = take && wb_we_i;
  assign rd       = take && !wb_we_i;
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= take;
    end
  end

  // Read data mux
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= '0;
    end else if (rd) begin
      dat_q <= '0;
      if (hit(wb_adr_i, XSTAT_ADDR)) begin
        dat_q[AN_FAULT]   <= fault_q;
        dat_q[AN_LP_NP]   <= lp_np_q;
        dat_q[AN_NP]      <= 1'b0;
        dat_q[AN_PAGE_RX] <= page_q;
        dat_q[AN_LP_AN]   <= lp_an_q;
      end else if (hit(wb_adr_i, CFG_ADDR)) begin
        dat_q[REG_W-1:0]  <= cfg_q;
        dat_q[CF_TX100]   <= 1'b1;
        dat_q[CF_SM_RESET] <= sm_busy;
      end else if (hit(wb_adr_i, IRQ_STAT_ADDR)) begin
        dat_q[IRQ_W-1:0]  <= irq_stat_q;
      end else if (hit(wb_adr_i, IRQ_MASK_ADDR)) begin
        dat_q[IRQ_W-1:0]  <= irq_mask_q;
      end
    end
  end

  // Latched fault: set wins, clears on read only once fault is gone
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_q <= 1'b0;
    end else if (pd_fault_i) begin
      fault_q <= 1'b1;
    end else if (rd && hit(wb_adr_i, XSTAT_ADDR) && !pd_fault_active_i) begin
      fault_q <= 1'b0;
    end
  end

  // Page received: set wins over read clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      page_q <= 1'b0;
    end else if (page_rx_i) begin
      page_q <= 1'b1;
    end else if (rd && hit(wb_adr_i, XSTAT_ADDR)) begin
      page_q <= 1'b0;
    end
  end

  // Partner abilities
  always_ff @(posedge clk_i) begin
    if (rst_i || sm_busy) begin
      lp_np_q <= 1'b0;
      lp_an_q <= 1'b0;
    end else begin
      lp_np_q <= partner_np_i;
      lp_an_q <= partner_an_i;
    end
  end

  // Config register; RO bits are stored, but every write reloads them from CFG_RESET
  always_comb begin
    cfg_d = cfg_q;
    if (wr && hit(wb_adr_i, CFG_ADDR)) begin
      cfg_d = (merge16(cfg_q, wb_dat_i, wb_sel_i) & CFG_WMASK) | (CFG_RESET & ~CFG_WMASK);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q <= CFG_RESET;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // Reset sequencer start: reset bit write or wake from sleep
  assign sm_start = (wr && hit(wb_adr_i, CFG_ADDR) && wb_sel_i[0] && wb_dat_i[CF_SM_RESET])
                    || wake;
  assign wake     = cfg_q[CF_SLEEP] && !cfg_d[CF_SLEEP];

  paec_state_machine_reset_seq #(
    .CYCLES (SM_RESET_CYCLES)
  ) u_seq (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (sm_start),
    .busy_o  (sm_busy),
    .done_o  (sm_done)
  );

  assign sm_reset_o          = sm_busy;
  assign coding_bypass_o     = cfg_q[CF_CODING];
  assign scrambler_bypass_o  = cfg_q[CF_SCRAMBLER];
  assign alignment_bypass_o  = cfg_q[CF_ALIGN];
  assign force_link_100_o    = cfg_q[CF_FLINK];
  assign arpd_enable_o       = cfg_q[CF_ARPD];
  assign preamble_suppress_o = cfg_q[CF_PREAMBLE];
  assign sleep_o             = cfg_q[CF_SLEEP];
  assign remote_loop_out_o   = cfg_q[CF_LOOPOUT];
  assign signal_detect_o     = sigdet_q;
  assign link_status_o       = link_q;

  // Forced detector and link indications
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sigdet_q <= 1'b0;
      link_q   <= 1'b0;
    end else begin
      sigdet_q <= signal_detect_i || cfg_q[CF_SIG_DET];
      link_q <= link_up_i || cfg_q[CF_FLINK];
    end
  end

  // Interrupt status: sticky, read clears, set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_q <= '0;
    end else begin
      if (rd && hit(wb_adr_i, IRQ_STAT_ADDR)) begin
        irq_stat_q <= '0;
      end
      if (pd_fault_i) begin
        irq_stat_q[IRQ_FAULT] <= 1'b1;
      end
      if (page_rx_i) begin
        irq_stat_q[IRQ_PAGE] <= 1'b1;
      end
      if (sm_done) begin
        irq_stat_q[IRQ_SMDONE] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_q <= IRQ_MASK_RESET;
    end else if (wr && hit(wb_adr_i, IRQ_MASK_ADDR) && wb_sel_i[0]) begin
      irq_mask_q <= wb_dat_i[IRQ_W-1:0];
    end
  end

  assign irq_o = |(irq_stat_q & irq_mask_q);

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence cfg_write_s(int bit_idx, logic val);
    wr && hit(wb_adr_i, CFG_ADDR) && wb_sel_i[bit_idx / 8] && wb_dat_i[bit_idx] == val;
  endsequence

  sequence xstat_read_s;
    rd && hit(wb_adr_i, XSTAT_ADDR);
  endsequence

  fault_set_a: assert property (pd_fault_i |=> fault_q ##1 (wb_ack_o || fault_q))
    else $error("fault flag not set");

  fault_hold_a: assert property (fault_q && !(rd && hit(wb_adr_i, XSTAT_ADDR) && !pd_fault_active_i)
                                 |=> fault_q)
    else $error("fault flag dropped early");

  lp_np_read_a: assert property (xstat_read_s ##1 wb_ack_o |->
                                 wb_dat_o[AN_LP_NP] == $past(lp_np_q))
    else $error("partner next page bit wrong");

  np_zero_a: assert property (xstat_read_s |=> wb_ack_o && !wb_dat_o[AN_NP])
    else $error("local next page bit not zero");

  page_clear_a: assert property (xstat_read_s ##0 !page_rx_i |=> !page_q)
    else $error("page flag not cleared by read");

  page_set_a: assert property (page_rx_i |=> page_q)
    else $error("page flag not set");

  lp_an_a: assert property (!sm_busy && $past(!sm_busy) |-> lp_an_q == $past(partner_an_i))
    else $error("partner autoneg bit wrong");

  coding_wr_a: assert property (cfg_write_s(CF_CODING, 1'b1) |=> coding_bypass_o)
    else $error("coding bypass not set");

  scram_wr_a: assert property (cfg_write_s(CF_SCRAMBLER, 1'b0) |=> !scrambler_bypass_o)
    else $error("scrambler bypass not cleared");

  align_wr_a: assert property (cfg_write_s(CF_ALIGN, 1'b1) |=> alignment_bypass_o)
    else $error("alignment bypass not set");

  sigdet_force_a: assert property (cfg_q[CF_SIG_DET] |=> signal_detect_o)
    else $error("signal detect not forced");

  tx_bit_a: assert property (rd && hit(wb_adr_i, CFG_ADDR) |=> wb_dat_o[CF_TX100])
    else $error("100BASE-TX bit not one");

  flink_a: assert property (force_link_100_o |=> link_status_o)
    else $error("forced link not reported");

  arpd_rst_a: assert property ($past(rst_i) |-> arpd_enable_o && !sleep_o)
    else $error("config reset value wrong");

  state_machine_reset_seq_a: assert property (cfg_write_s(CF_SM_RESET, 1'b1) |=>
                                sm_reset_o [*8] ##[1:20] !sm_reset_o)
    else $error("state machine reset pulse wrong");

  state_machine_reset_clear_a: assert property (rd && hit(wb_adr_i, CFG_ADDR) && !sm_busy |=>
                                  !wb_dat_o[CF_SM_RESET])
    else $error("state machine reset did not end");

  preamble_wr_a: assert property (cfg_write_s(CF_PREAMBLE, 1'b1) |=> preamble_suppress_o)
    else $error("preamble suppression not set");

  sleep_wr_a: assert property (cfg_write_s(CF_SLEEP, 1'b1) |=> sleep_o)
    else $error("sleep not entered");

  wake_a: assert property ($fell(sleep_o) |-> sm_reset_o && $stable(coding_bypass_o))
    else $error("wake did not reset state machines");

  loopout_wr_a: assert property (cfg_write_s(CF_LOOPOUT, 1'b1) |=> remote_loop_out_o)
    else $error("remote loop-out not set");

  irq_level_a: assert property (page_rx_i && irq_mask_q[IRQ_PAGE]
                                && !(wr && hit(wb_adr_i, IRQ_MASK_ADDR)) |=> irq_o)
    else $error("interrupt not raised");
endmodule : paec_regs

// >>> paec_state_machine_reset_seq.sv
// Purpose: Timed reset pulse for the PHY state machines.
// Assumes: start_i is a one-cycle pulse on clk_i.
// Notes: A start while busy restarts the count.
`timescale 1ns/100ps
module paec_state_machine_reset_seq #(
  parameter int CYCLES = paec_pkg::SM_RESET_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic start_i,
  output logic      busy_o,
  output logic      done_o
);
  import paec_pkg::*;

  localparam int CNT_W = $clog2(CYCLES + 1);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

  paec_seq_state_t  state_q;
  logic [CNT_W-1:0] cnt_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= SEQ_IDLE;
    end else if (start_i) begin
      state_q <= SEQ_HOLD;
    end else begin
      case (state_q)
        SEQ_IDLE: state_q <= SEQ_IDLE;
        SEQ_HOLD: state_q <= (cnt_q == LAST) ? SEQ_DONE : SEQ_HOLD;
        SEQ_DONE: state_q <= SEQ_IDLE;
        default:  state_q <= SEQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || start_i) begin
      cnt_q <= '0;
    end else if (state_q == SEQ_HOLD) begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  assign busy_o = (state_q == SEQ_HOLD);
  assign done_o = (state_q == SEQ_DONE);
endmodule : paec_state_machine_reset_seq

// >>> tb.sv
// Purpose: Self-checking bench for the expansion and config registers.
// Assumes: Wishbone ack one cycle after the request is taken.
// Notes: Random config values from a fixed seed.
`timescale 1ns/100ps
module tb;
  import paec_pkg::*;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic pd_fault_i, pd_fault_active_i, page_rx_i, partner_np_i, partner_an_i;
  logic signal_detect_i, link_up_i, coding_bypass_o, scrambler_bypass_o;
  logic alignment_bypass_o, signal_detect_o, link_status_o, force_link_100_o;
  logic arpd_enable_o, sm_reset_o, preamble_suppress_o, sleep_o, remote_loop_out_o;
  int n_fail, checks, cyc_cnt, sm_len;
  integer seed;
  logic [3:0] sel_v;

  paec_regs u_paec_regs (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pd_fault_i, .pd_fault_active_i,
    .page_rx_i, .partner_np_i, .partner_an_i, .signal_detect_i, .link_up_i,
    .coding_bypass_o, .scrambler_bypass_o, .alignment_bypass_o, .signal_detect_o,
    .link_status_o, .force_link_100_o, .arpd_enable_o, .sm_reset_o,
    .preamble_suppress_o, .sleep_o, .remote_loop_out_o, .irq_o);

  paec_phy_model u_phy (.clk_i, .pd_fault_o(pd_fault_i), .pd_active_o(pd_fault_active_i),
    .page_rx_o(page_rx_i), .partner_np_o(partner_np_i), .partner_an_o(partner_an_i),
    .sig_det_o(signal_detect_i), .link_up_o(link_up_i));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cyc_cnt++;
    if (sm_reset_o === 1'b1) sm_len++;
    if (cyc_cnt == 20000) begin
      n_fail++;
      complete_run();
    end
  end

  function automatic logic [31:0] cfg_exp(input logic [15:0] w);
    return {16'h0000, (w & CFG_WMASK) | 16'h0400};
  endfunction : cfg_exp

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wb(input logic we, input logic [7:0] adr, input logic [15:0] d,
                    output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel_v;
    wb_dat_i <= {16'h0000, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] adr, input logic [15:0] d);
    logic [31:0] q;
    wb(1'b1, adr, d, q);
  endtask : wr

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, adr, 16'h0000, q);
    check(q, exp);
  endtask : rd_chk

  task automatic complete_run();
    $display("checks %0d, n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run

  initial begin
    logic [15:0] w;
    logic [4:0]  l;
    seed = 32'hd9954df4;
    sel_v = 4'h3;
    {n_fail, checks, cyc_cnt, sm_len} = '0;
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h8;
    {wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values
    rd_chk(XSTAT_ADDR, 32'h0);
    rd_chk(CFG_ADDR, 32'h0410);
    rd_chk(IRQ_MASK_ADDR, 32'h0);
    check(arpd_enable_o, 1'b1);
    rd_chk(IRQ_STAT_ADDR, 32'h0);
    // Random config and line levels, with all-set (bar reset and sleep bits) and all-clear config corners
    for (int i = 0; i < 14; i++) begin
      w = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : 16'($random(seed));
      w[CF_SM_RESET] = 1'b0;
      w[CF_SLEEP] = 1'b0;
      l = 5'($random(seed)) & 5'h0f;
      u_phy.levels(l);
      wr(CFG_ADDR, w);
      rd_chk(CFG_ADDR, cfg_exp(w));
      rd_chk(XSTAT_ADDR, {28'h0, l[3], 2'b00, l[2]});
      check({coding_bypass_o, scrambler_bypass_o, alignment_bypass_o, force_link_100_o},
            {w[15], w[14], w[13], w[7]});
      check({arpd_enable_o, preamble_suppress_o, remote_loop_out_o},
            {w[4], w[2], w[0]});
      check({signal_detect_o, link_status_o}, {l[1] | w[12], l[0] | w[7]});
    end
    u_phy.levels(5'h00);
    // State machine reset: busy while running, then self-clears
    sm_len = 0;
    wr(CFG_ADDR, 16'h0018);
    rd_chk(CFG_ADDR, 32'h0418);
    repeat (15) @(posedge clk_i);
    check(sm_len, SM_RESET_CYCLES);
    rd_chk(CFG_ADDR, 32'h0410);
    rd_chk(IRQ_STAT_ADDR, 32'h4);
    // Sleep, then wake keeping config
    wr(CFG_ADDR, 16'h8013);
    check(sleep_o, 1'b1);
    sm_len = 0;
    wr(CFG_ADDR, 16'h8011);
    repeat (15) @(posedge clk_i);
    check(sm_len, SM_RESET_CYCLES);
    rd_chk(CFG_ADDR, 32'h8411);
    check({coding_bypass_o, sleep_o, remote_loop_out_o}, 3'b101);
    rd_chk(IRQ_STAT_ADDR, 32'h4);
    // Latched flags; fault held while still present
    u_phy.levels(5'h10);
    u_phy.pulse(1'b1);
    u_phy.pulse(1'b0);
    rd_chk(XSTAT_ADDR, 32'h12);
    rd_chk(XSTAT_ADDR, 32'h10);
    u_phy.levels(5'h00);
    rd_chk(XSTAT_ADDR, 32'h10);
    rd_chk(XSTAT_ADDR, 32'h0);
    rd_chk(IRQ_STAT_ADDR, 32'h3);
    // Read-only and unmapped places ignore writes
    wr(XSTAT_ADDR, 16'hffff);
    rd_chk(XSTAT_ADDR, 32'h0);
    wr(8'hfc, 16'hffff);
    rd_chk(8'hfc, 32'h0);
    rd_chk(CFG_ADDR, 32'h8411);
    // Interrupt masking
    wr(IRQ_MASK_ADDR, 16'h0001);
    u_phy.pulse(1'b0);
    repeat (2) @(posedge clk_i);
    check(irq_o, 1'b0);
    wr(IRQ_MASK_ADDR, 16'h0002);
    check(irq_o, 1'b1);
    rd_chk(IRQ_MASK_ADDR, 32'h2);
    rd_chk(IRQ_STAT_ADDR, 32'h2);
    check(irq_o, 1'b0);
    // Low byte lane only: upper config bits keep their value
    sel_v = 4'h1;
    wr(CFG_ADDR, 16'h00a5);
    sel_v = 4'h3;
    rd_chk(CFG_ADDR, 32'h8485);
    complete_run();
  end
endmodule : tb
